// ===== hdl/edc_pkg.sv
package edc_pkg;
  localparam int ROW_W = 10;
  localparam int COL_W = 10;
  localparam int ADDR_W = 20;
  localparam int DQ_W = 16;
  localparam int BE_W = 2;
  localparam int CMD_W = 1 + BE_W + ADDR_W + DQ_W;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_PERIOD_PS = 50000;
  // Power-up pause, least time
  localparam int PWRUP_PAUSE_US = 200;
  localparam int PWRUP_CYCLES = (PWRUP_PAUSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Refresh period and rows, longest spacing per row
  localparam int REF_PERIOD_MS = 16;
  localparam int REF_ROWS = 1024;
  localparam longint REF_PERIOD_PS = longint'(REF_PERIOD_MS) * 64'd1000000000;
  localparam int REF_CYCLES = int'(REF_PERIOD_PS / (longint'(REF_ROWS) * CLK_PERIOD_PS));
  localparam int WAKE_CYCLES = 8;
  localparam logic [BE_W-1:0] BE_NONE = 2'h0;
  localparam logic [DQ_W-1:0] DQ_ZERO = 16'h0000;
  localparam logic [ROW_W-1:0] ROW_ZERO = 10'h000;
  typedef enum logic [3:0] {
    ST_PWRUP, ST_IDLE, ST_LOAD, ST_ROW, ST_COL, ST_ACC, ST_END, ST_PRE,
    ST_CBR_CAS, ST_CBR_RAS, ST_CBR_HOLD
  } edc_state_t;
endpackage

// ===== hdl/edc_fifo_if.sv
`timescale 1ns/1ps
interface edc_fifo_if #(parameter int WIDTH = 39);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  modport fifo (input in_valid, output in_ready, input in_data,
                output out_valid, input out_ready, output out_data);
  modport user (output in_valid, input in_ready, output in_data,
                input out_valid, output out_ready, input out_data);
endinterface

// ===== hdl/edc_fifo.sv
`timescale 1ns/1ps
// Out data is registered: it appears the cycle after out_ready meets out_valid
module edc_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  edc_fifo_if.fifo port
);
  import edc_pkg::*;
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wptr_ff;
  logic [PW-1:0] rptr_ff;
  logic [PW:0] cnt_ff;
  logic [PW:0] nxt_cnt;
  logic full_ff;
  logic empty_ff;
  logic in_ready_ff;
  logic [WIDTH-1:0] data_ff;
  logic push;
  logic pop;

  assign push = port.in_valid && !full_ff;
  assign pop = port.out_ready && !empty_ff;
  assign port.in_ready = in_ready_ff;
  assign port.out_valid = !empty_ff;
  assign port.out_data = data_ff;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wptr_ff] <= port.in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff <= '0;
      full_ff <= 1'b0;
      empty_ff <= 1'b1;
      in_ready_ff <= 1'b1;
      data_ff <= '0;
    end else begin
      if (push) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= rptr_ff + 1'b1;
        data_ff <= mem_ff[rptr_ff];
      end
      cnt_ff <= nxt_cnt;
      full_ff <= (nxt_cnt == (PW+1)'(DEPTH));
      // Ready kept in its own flop so it leaves the block straight from a register
      in_ready_ff <= (nxt_cnt != (PW+1)'(DEPTH));
      empty_ff <= (nxt_cnt == '0);
    end
  end
endmodule

// ===== hdl/edc_ref_timer.sv
`timescale 1ns/1ps
module edc_ref_timer #(
  parameter int PWRUP_CNT = edc_pkg::PWRUP_CYCLES,
  parameter int REF_CNT = edc_pkg::REF_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic pause_done,
  output logic ref_tick
);
  import edc_pkg::*;
  logic [15:0] pause_ff;
  logic [15:0] ref_ff;
  logic pause_done_ff;
  logic ref_tick_ff;

  assign pause_done = pause_done_ff;
  assign ref_tick = ref_tick_ff;

  ////////////////////////////////////////////////////////////////
  // Power-up pause
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pause_ff <= '0;
      pause_done_ff <= 1'b0;
    end else if (!pause_done_ff) begin
      pause_ff <= pause_ff + 1'b1;
      pause_done_ff <= (pause_ff == 16'(PWRUP_CNT - 1));
    end
  end

  ////////////////////////////////////////////////////////////////
  // One tick per refresh slot, running once the pause is over
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ref_ff <= '0;
      ref_tick_ff <= 1'b0;
    end else begin
      ref_tick_ff <= 1'b0;
      if (pause_done_ff) begin
        if (ref_ff == 16'(REF_CNT - 1)) begin
          ref_ff <= '0;
          ref_tick_ff <= 1'b1;
        end else begin
          ref_ff <= ref_ff + 1'b1;
        end
      end
    end
  end
endmodule

// ===== hdl/edc_ctrl.sv
`timescale 1ns/1ps
module edc_ctrl #(
  parameter int PWRUP_CNT = edc_pkg::PWRUP_CYCLES,
  parameter int REF_CNT = edc_pkg::REF_CYCLES,
  parameter int DEPTH = edc_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [edc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [edc_pkg::BE_W-1:0] req_be,
  input wire logic [edc_pkg::DQ_W-1:0] req_wdata,
  output logic rd_valid,
  output logic [edc_pkg::DQ_W-1:0] rd_data,
  output logic init_done,
  output logic ras_n,
  output logic lower_byte_strobe_n,
  output logic upper_byte_strobe_n,
  output logic we_n,
  output logic oe_n,
  output logic [edc_pkg::ROW_W-1:0] mem_addr,
  input wire logic [edc_pkg::DQ_W-1:0] dq_in,
  output logic [edc_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe
);
  import edc_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Request queue
  edc_fifo_if #(.WIDTH(CMD_W)) q_if ();
  logic pause_done;
  logic ref_tick;
  logic pop_now;

  assign q_if.in_valid = req_valid;
  assign q_if.in_data = {req_write, req_be, req_addr, req_wdata};
  assign req_ready = q_if.in_ready;
  assign q_if.out_ready = pop_now;

  edc_fifo #(.WIDTH(CMD_W), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .port(q_if.fifo)
  );

  edc_ref_timer #(.PWRUP_CNT(PWRUP_CNT), .REF_CNT(REF_CNT)) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .pause_done(pause_done),
    .ref_tick(ref_tick)
  );

  ////////////////////////////////////////////////////////////////
  // Refresh bookkeeping
  edc_state_t state_ff;
  edc_state_t nxt_state;
  logic ref_pend_ff;
  logic rewake_ff;
  logic [3:0] wake_left_ff;
  logic init_done_ff;
  logic cbr_start;
  logic wake_start;

  assign cbr_start = (state_ff == ST_CBR_CAS);
  assign wake_start = (state_ff == ST_PWRUP && pause_done) || (state_ff == ST_IDLE && rewake_ff);

  // A tick coinciding with the start of a refresh re-arms the request
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ref_pend_ff <= 1'b0;
    end else if (ref_tick) begin
      ref_pend_ff <= 1'b1;
    end else if (cbr_start) begin
      ref_pend_ff <= 1'b0;
    end
  end

  // A second tick while one is still owed means the period was missed
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rewake_ff <= 1'b0;
    end else if (ref_tick && ref_pend_ff && !cbr_start) begin
      rewake_ff <= 1'b1;
    end else if (wake_start) begin
      rewake_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wake_left_ff <= 4'h0;
    end else if (wake_start) begin
      wake_left_ff <= 4'(WAKE_CYCLES);
    end else if (cbr_start && wake_left_ff != 4'h0) begin
      wake_left_ff <= wake_left_ff - 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      init_done_ff <= 1'b0;
    end else if (state_ff == ST_PRE && wake_left_ff == 4'h0 && pause_done) begin
      init_done_ff <= 1'b1;
    end
  end
  assign init_done = init_done_ff;

  ////////////////////////////////////////////////////////////////
  // Cycle sequencer
  logic cmd_wr_ff;
  logic [BE_W-1:0] cmd_be_ff;
  logic [ADDR_W-1:0] cmd_addr_ff;
  logic [DQ_W-1:0] cmd_wdata_ff;
  // Queue head fields, settled during ST_LOAD because the pop happens on leaving idle
  logic head_wr;
  logic [BE_W-1:0] head_be;
  logic [ADDR_W-1:0] head_addr;
  logic [DQ_W-1:0] head_wdata;

  assign {head_wr, head_be, head_addr, head_wdata} = q_if.out_data;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_PWRUP: begin
        if (pause_done) begin
          nxt_state = ST_CBR_CAS;
        end
      end
      ST_IDLE: begin
        if (rewake_ff || ref_pend_ff || wake_left_ff != 4'h0) begin
          nxt_state = ST_CBR_CAS;
        end else if (q_if.out_valid && init_done_ff) begin
          nxt_state = ST_LOAD;
        end
      end
      ST_LOAD: nxt_state = ST_ROW;
      ST_ROW: nxt_state = ST_COL;
      ST_COL: nxt_state = ST_ACC;
      ST_ACC: nxt_state = ST_END;
      ST_END: nxt_state = ST_PRE;
      ST_PRE: nxt_state = ST_IDLE;
      ST_CBR_CAS: nxt_state = ST_CBR_RAS;
      ST_CBR_RAS: nxt_state = ST_CBR_HOLD;
      ST_CBR_HOLD: nxt_state = ST_PRE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= ST_PWRUP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // The queue's output word is registered, so it is popped one cycle ahead of its use
  assign pop_now = (state_ff == ST_IDLE && nxt_state == ST_LOAD);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_wr_ff <= 1'b0;
      cmd_be_ff <= BE_NONE;
      cmd_addr_ff <= '0;
      cmd_wdata_ff <= DQ_ZERO;
    end else if (state_ff == ST_LOAD) begin
      {cmd_wr_ff, cmd_be_ff, cmd_addr_ff, cmd_wdata_ff} <= q_if.out_data;
    end
  end

  // Command steering the pins: the queue head while loading, its held copy after that
  logic cur_wr;
  logic [BE_W-1:0] cur_be;
  logic [ADDR_W-1:0] cur_addr;
  logic [DQ_W-1:0] cur_wdata;

  always_comb begin
    if (state_ff == ST_LOAD) begin
      cur_wr = head_wr;
      cur_be = head_be;
      cur_addr = head_addr;
      cur_wdata = head_wdata;
    end else begin
      cur_wr = cmd_wr_ff;
      cur_be = cmd_be_ff;
      cur_addr = cmd_addr_ff;
      cur_wdata = cmd_wdata_ff;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pin drivers
  logic ras_n_ff;
  logic lower_byte_strobe_n_n_ff;
  logic upper_byte_strobe_n_n_ff;
  logic we_n_ff;
  logic oe_n_ff;
  logic [ROW_W-1:0] addr_ff;
  logic [DQ_W-1:0] dq_out_ff;
  logic dq_oe_ff;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ras_n_ff <= 1'b1;
      lower_byte_strobe_n_n_ff <= 1'b1;
      upper_byte_strobe_n_n_ff <= 1'b1;
    end else begin
      unique case (nxt_state)
        ST_ROW: ras_n_ff <= 1'b0;
        ST_COL: begin
          lower_byte_strobe_n_n_ff <= !cur_be[0];
          upper_byte_strobe_n_n_ff <= !cur_be[1];
        end
        ST_CBR_CAS: begin
          lower_byte_strobe_n_n_ff <= 1'b0;
          upper_byte_strobe_n_n_ff <= 1'b0;
        end
        ST_CBR_RAS: ras_n_ff <= 1'b0;
        ST_END, ST_PRE: begin
          // Both strobes high for a full cycle clears held output data
          ras_n_ff <= 1'b1;
          lower_byte_strobe_n_n_ff <= 1'b1;
          upper_byte_strobe_n_n_ff <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // Write strobe falls one cycle before the column strobe: early write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
    end else begin
      we_n_ff <= !(cur_wr && (nxt_state == ST_ROW || nxt_state == ST_COL || nxt_state == ST_ACC));
      // Gate held high on writes and refreshes, low only across a read
      oe_n_ff <= !(!cur_wr && (nxt_state == ST_COL || nxt_state == ST_ACC));
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      addr_ff <= ROW_ZERO;
      dq_out_ff <= DQ_ZERO;
      dq_oe_ff <= 1'b0;
    end else begin
      if (nxt_state == ST_ROW) begin
        addr_ff <= cur_addr[ADDR_W-1:COL_W];
      end else if (nxt_state == ST_COL) begin
        addr_ff <= cur_addr[COL_W-1:0];
      end
      dq_out_ff <= cur_wdata;
      dq_oe_ff <= cur_wr && (nxt_state == ST_ROW || nxt_state == ST_COL || nxt_state == ST_ACC);
    end
  end

  assign ras_n = ras_n_ff;
  assign lower_byte_strobe_n = lower_byte_strobe_n_n_ff;
  assign upper_byte_strobe_n = upper_byte_strobe_n_n_ff;
  assign we_n = we_n_ff;
  assign oe_n = oe_n_ff;
  assign mem_addr = addr_ff;
  assign dq_out = dq_out_ff;
  assign dq_oe = dq_oe_ff;

  ////////////////////////////////////////////////////////////////
  // Read return, sampled before any strobe rises
  logic rd_valid_ff;
  logic [DQ_W-1:0] rd_data_ff;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff <= DQ_ZERO;
    end else begin
      rd_valid_ff <= (state_ff == ST_ACC && !cmd_wr_ff);
      if (state_ff == ST_ACC && !cmd_wr_ff) begin
        rd_data_ff <= dq_in;
      end
    end
  end

  assign rd_valid = rd_valid_ff;
  assign rd_data = rd_data_ff;
endmodule

// ===== dv/edc_ctrl_properties.sv
`timescale 1ns/1ps
module edc_ctrl_properties #(
  parameter int PWRUP_CNT = 20,
  parameter int REF_CNT = 60
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req_ready,
  input wire logic init_done,
  input wire logic ras_n,
  input wire logic lower_byte_strobe_n,
  input wire logic upper_byte_strobe_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic dq_oe
);
  logic [15:0] since_rst_ff;
  logic [15:0] since_ref_ff;
  logic [3:0] cbr_cnt_ff;
  logic ras_q_ff;
  logic cbr_fall;
  //////////////////////////////
  assign cbr_fall = ras_q_ff && !ras_n && !lower_byte_strobe_n;
  always_ff @(posedge clock) begin
    ras_q_ff <= rst_n ? ras_n : 1'b1;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) since_rst_ff <= 16'h0000;
    else if (since_rst_ff != 16'hffff) since_rst_ff <= since_rst_ff + 16'h0001;
  end
  always_ff @(posedge clock) begin
    if (!rst_n || cbr_fall) since_ref_ff <= 16'h0000;
    else if (since_ref_ff != 16'hffff) since_ref_ff <= since_ref_ff + 16'h0001;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) cbr_cnt_ff <= 4'h0;
    else if (cbr_fall && cbr_cnt_ff != 4'hf) cbr_cnt_ff <= cbr_cnt_ff + 4'h1;
  end
  //////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_pause_first;
    (since_rst_ff < PWRUP_CNT - 1) |-> ras_n && lower_byte_strobe_n && upper_byte_strobe_n;
  endproperty
  a_pause_first: assert property (p_pause_first) else $error("strobe active during power-up pause");
  property p_wake_count;
    $rose(init_done) |-> cbr_cnt_ff >= 4'h8;
  endproperty
  a_wake_count: assert property (p_wake_count) else $error("ready before eight refreshes");
  property p_ref_gap;
    init_done |-> since_ref_ff <= REF_CNT + 24;
  endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("refresh spacing too long");
  property p_precharge;
    $rose(ras_n) |-> (ras_n && lower_byte_strobe_n && upper_byte_strobe_n) [*2];
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge shorter than two cycles");
  property p_write_setup;
    $fell(lower_byte_strobe_n) && !ras_n && !we_n |-> $past(we_n) == 1'b0;
  endproperty
  a_write_setup: assert property (p_write_setup) else $error("write strobe not ahead of column");
  property p_write_gate;
    dq_oe |-> oe_n;
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("gate low while driving data");
  property p_we_cmd;
    $fell(we_n) |-> dq_oe && !ras_n;
  endproperty
  a_we_cmd: assert property (p_we_cmd) else $error("write strobe without data");
  property p_cbr_shape;
    $fell(lower_byte_strobe_n) && ras_n |-> !upper_byte_strobe_n ##1 !ras_n [*2] ##1 ras_n;
  endproperty
  a_cbr_shape: assert property (p_cbr_shape) else $error("bad refresh strobe order");
  property p_gate_in_row;
    !oe_n |-> !ras_n && we_n;
  endproperty
  a_gate_in_row: assert property (p_gate_in_row) else $error("gate low outside a read");
  c_init: cover property ($rose(init_done));
  c_refresh: cover property (cbr_fall && init_done);
  c_write: cover property ($fell(we_n));
  c_full: cover property (!req_ready && init_done);
endmodule

// ===== dv/edc_dram_model.sv
`timescale 1ns/1ps
module edc_dram_model (
  input wire logic ras_n,
  input wire logic lower_byte_strobe_n,
  input wire logic upper_byte_strobe_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [edc_pkg::ROW_W-1:0] mem_addr,
  input wire logic [edc_pkg::DQ_W-1:0] dq_out,
  input wire logic dq_oe,
  output logic [edc_pkg::DQ_W-1:0] dq_in,
  output int refresh_total
);
  import edc_pkg::*;
  logic [DQ_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ROW_W-1:0] row = ROW_ZERO;
  logic [DQ_W-1:0] word = DQ_ZERO;
  logic [ADDR_W-1:0] loc;
  logic early_wr = 1'b0;
  logic lo_on;
  logic hi_on;
  initial refresh_total = 0;
  //////////////////////////////
  // Short wait lets the address launched with the strobe settle
  always @(negedge ras_n) begin
    #1;
    early_wr = 1'b0;
    if (!lower_byte_strobe_n || !upper_byte_strobe_n) refresh_total++;
    else row = mem_addr;
  end
  always @(negedge lower_byte_strobe_n or negedge upper_byte_strobe_n) begin
    #1;
    if (!ras_n) begin
      loc = {row, mem_addr};
      word = mem.exists(loc) ? mem[loc] : DQ_ZERO;
      if (!we_n) begin
        early_wr = 1'b1;
        if (!lower_byte_strobe_n) word[7:0] = dq_out[7:0];
        if (!upper_byte_strobe_n) word[15:8] = dq_out[15:8];
        mem[loc] = word;
      end
    end
  end
  assign lo_on = !lower_byte_strobe_n && !oe_n && we_n && !early_wr;
  assign hi_on = !upper_byte_strobe_n && !oe_n && we_n && !early_wr;
  // Write strobe falling inside an open column cycle: late write, data taken at that edge
  always @(negedge we_n) begin
    #1;
    if (!ras_n && (!lower_byte_strobe_n || !upper_byte_strobe_n) && !early_wr) begin
      if (!lower_byte_strobe_n) word[7:0] = dq_out[7:0];
      if (!upper_byte_strobe_n) word[15:8] = dq_out[15:8];
      mem[loc] = word;
    end
  end
  // Released lanes show the inverse of the last word
  always_comb begin
    dq_in = dq_oe ? dq_out : ~word;
    if (lo_on) dq_in[7:0] = word[7:0];
    if (hi_on) dq_in[15:8] = word[15:8];
  end
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
  import edc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [BE_W-1:0] req_be = BE_NONE;
  logic [DQ_W-1:0] req_wdata = DQ_ZERO;
  logic req_ready, rd_valid, init_done, ras_n, we_n, oe_n, dq_oe, full_seen;
  logic lower_byte_strobe_n, upper_byte_strobe_n;
  logic [DQ_W-1:0] rd_data, dq_in, dq_out;
  logic [ROW_W-1:0] mem_addr;
  int refresh_total;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  always #25 clock = ~clock;
  edc_ctrl #(.PWRUP_CNT(20), .REF_CNT(60)) dut_u (.clock, .rst_n, .req_valid, .req_ready, .req_write,
    .req_addr, .req_be, .req_wdata, .rd_valid, .rd_data, .init_done, .ras_n, .lower_byte_strobe_n,
    .upper_byte_strobe_n, .we_n, .oe_n, .mem_addr, .dq_in, .dq_out, .dq_oe);
  edc_dram_model mem_u (.ras_n, .lower_byte_strobe_n, .upper_byte_strobe_n, .we_n, .oe_n, .mem_addr,
    .dq_out, .dq_oe, .dq_in, .refresh_total);
  //////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [DQ_W-1:0] exp, input logic [DQ_W-1:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  // Called at a falling edge; leaves the request raised at the one after req_ready is seen high
  task automatic push(input logic wr, input logic [ADDR_W-1:0] a, input logic [BE_W-1:0] be,
                      input logic [DQ_W-1:0] d);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_be = be;
    req_wdata = d;
    while (req_ready !== 1'b1) begin
      full_seen = 1'b1;
      @(negedge clock);
    end
    @(negedge clock);
  endtask
  task automatic read_word(input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] exp, input string what);
    push(1'b0, a, 2'h3, DQ_ZERO);
    req_valid = 1'b0;
    while (rd_valid !== 1'b1) @(negedge clock);
    chk(what, exp, rd_data);
    @(negedge clock);
  endtask
  //////////////////////////////
  task automatic wake_up();
    push(1'b1, 20'h0_0c05, 2'h3, 16'h5a3c);
    req_valid = 1'b0;
    repeat (15) @(negedge clock);
    chk("early refreshes", 16'h0000, 16'(refresh_total));
    while (init_done !== 1'b1) @(negedge clock);
    chk("wake refreshes", 16'h0001, {15'h0000, refresh_total >= 8});
    read_word(20'h0_0c05, 16'h5a3c, "queued before init");
  endtask
  task automatic lanes();
    push(1'b1, 20'h0_4411, 2'h3, 16'h1234);
    push(1'b1, 20'h0_4411, 2'h1, 16'hffcd);
    push(1'b1, 20'h0_4411, 2'h2, 16'hab77);
    push(1'b1, 20'h0_8822, 2'h3, 16'h0f0f);
    push(1'b1, 20'h0_8822, 2'h0, 16'h5555);
    req_valid = 1'b0;
    read_word(20'h0_4411, 16'habcd, "byte lanes");
    read_word(20'h0_8822, 16'h0f0f, "no lane");
  endtask
  task automatic fill_drain();
    full_seen = 1'b0;
    for (int i = 0; i < 20; i++) begin
      push(1'b1, {10'(i + 3), 10'(i * 37)}, 2'h3, 16'(16'h1000 + i * 273));
    end
    req_valid = 1'b0;
    chk("queue full", 16'h0001, {15'h0000, full_seen});
    for (int i = 0; i < 20; i++) begin
      read_word({10'(i + 3), 10'(i * 37)}, 16'(16'h1000 + i * 273), "queued word");
    end
  endtask
  task automatic idle_refresh();
    int r0;
    r0 = refresh_total;
    repeat (600) @(negedge clock);
    chk("idle refreshes", 16'h0001, {15'h0000, (refresh_total - r0) >= 9});
    read_word(20'h0_4411, 16'habcd, "after refresh");
  endtask
  initial begin
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    wake_up();
    lanes();
    fill_drain();
    idle_refresh();
    end_sim();
  end
endmodule
bind edc_ctrl edc_ctrl_properties #(.PWRUP_CNT(PWRUP_CNT), .REF_CNT(REF_CNT)) chk_u (.clock, .rst_n,
  .req_ready, .init_done, .ras_n, .lower_byte_strobe_n, .upper_byte_strobe_n, .we_n, .oe_n, .dq_oe);
